// [shared/ldr_pkg.sv]
// constants for the lookup-table distributed memory block
// assumes one 200 MHz clock and a classic Wishbone register port
package ldr_pkg;

   // register byte offsets
   localparam logic [7:0] LDR_OFS_CTRL   = 8'h00;
   localparam logic [7:0] LDR_OFS_STATUS = 8'h04;

   // control field positions and reset values
   localparam int         LDR_CTRL_MODE_LSB = 0;
   localparam int         LDR_CTRL_FALL_BIT = 2;
   localparam logic [1:0] LDR_MODE_RST      = 2'h0;
   localparam logic       LDR_FALL_RST      = 1'b0;

   // status field positions
   localparam int LDR_STAT_CNT_LSB  = 0;
   localparam int LDR_STAT_LAST_WE  = 8;
   localparam int LDR_STAT_WCLK_LVL = 9;
   localparam int LDR_STAT_RD0      = 10;
   localparam int LDR_STAT_RD1      = 11;

   // memory organisations
   localparam logic [1:0] LDR_MODE_SP16   = 2'h0;
   localparam logic [1:0] LDR_MODE_SP16X2 = 2'h1;
   localparam logic [1:0] LDR_MODE_SP32   = 2'h2;
   localparam logic [1:0] LDR_MODE_DP16   = 2'h3;

   // array geometry
   localparam int LDR_LOC_BITS = 4;
   localparam int LDR_TOT_BITS = 5;
   localparam int LDR_DEPTH    = 32;

   // unmapped reads return this
   localparam logic [31:0] LDR_UNMAPPED = 32'h0000_0000;

endpackage : ldr_pkg

// [rtl/ldr_mem.sv]
// bit-wide storage array, two write ports, two read ports
// assumes write strobes come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module ldr_mem #(
   parameter int                  ABITS = 5,
   parameter logic [(1<<ABITS)-1:0] INIT = '0
) (
   // clock
   input  wire logic             i_clk,
   // write ports
   input  wire logic             i_we0,
   input  wire logic [ABITS-1:0] i_waddr0,
   input  wire logic             i_wdata0,
   input  wire logic             i_we1,
   input  wire logic [ABITS-1:0] i_waddr1,
   input  wire logic             i_wdata1,
   // read ports
   input  wire logic [ABITS-1:0] i_raddr0,
   input  wire logic [ABITS-1:0] i_raddr1,
   output logic                  o_rdata0,
   output logic                  o_rdata1
);
   localparam int DEPTH = 1 << ABITS;

   if (ABITS < 1 || ABITS > 8) begin : g_chk
      $error("ldr_mem: ABITS out of range");
   end

   typedef struct packed {
      logic [DEPTH-1:0] bits;
      logic             rd0;
      logic             rd1;
   } ldr_mem_st_t;

   // contents come only from the load pattern, never from a reset
   ldr_mem_st_t st_q = {INIT, 1'b0, 1'b0};
   ldr_mem_st_t st_d;

   always_comb begin
      st_d = st_q;
      if (i_we0) begin
         st_d.bits[i_waddr0] = i_wdata0;
      end
      if (i_we1) begin
         st_d.bits[i_waddr1] = i_wdata1;
      end
      // reads follow the live address with no write edge involved
      st_d.rd0 = st_q.bits[i_raddr0];
      st_d.rd1 = st_q.bits[i_raddr1];
   end

   always_ff @(posedge i_clk) begin
      st_q <= st_d;
   end

   assign o_rdata0 = st_q.rd0;
   assign o_rdata1 = st_q.rd1;

endmodule : ldr_mem
`default_nettype wire

// [rtl/ldr_top.sv]
// lookup-table distributed memory: write control, mode steering, registers
// assumes the write clock arrives as a pin and is oversampled by i_clk
// Function
// - writes on clock edge, reads need no write clock
// - single port: 16x1, two 16x1, 32x1
// - dual port only as one 16x1
// - 16x1 shares one 4-bit address
// - two arrays share enable and write clock
// - 32x1 adds upper address bit input
// - dual port decodes two 4-bit addresses
// - write and second read run together
// - capture at edge, then internal write pulse
// - write edge rising by default, or falling
// - write edge independent of cell flop clock
// - write enable active high, never inverted
// - address change updates read output one i_clk cycle later, no write clock
// - overwriting addressed location shows new value
// - single port one operation, dual concurrent
// - second output follows independent read address
// - contents loaded from pattern or zeros
// - global set/reset leaves contents unchanged
`timescale 1ns/1ps
`default_nettype none
module ldr_top #(
   parameter int                        LOC_BITS = ldr_pkg::LDR_LOC_BITS,
   parameter logic [ldr_pkg::LDR_DEPTH-1:0] INIT  = '0
) (
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   // wishbone slave
   input  wire logic                i_wb_cyc,
   input  wire logic                i_wb_stb,
   input  wire logic                i_wb_we,
   input  wire logic [7:0]          i_wb_adr,
   input  wire logic [3:0]          i_wb_sel,
   input  wire logic [31:0]         i_wb_dat,
   output logic      [31:0]         o_wb_dat,
   output logic                     o_wb_ack,
   // memory user side
   input  wire logic                i_write_clk,
   input  wire logic                i_write_en,
   input  wire logic [LOC_BITS-1:0] i_addr,
   input  wire logic                i_upper_addr_bit,
   input  wire logic [LOC_BITS-1:0] i_independent_read_addr,
   input  wire logic                i_write_data_in,
   input  wire logic                i_second_write_data_in,
   output logic                     o_addressed_read_out,
   output logic                     o_second_read_out
);
   localparam int TB = LOC_BITS + 1;

   if (LOC_BITS != ldr_pkg::LDR_LOC_BITS) begin : g_chk
      $error("ldr_top: only 16-location arrays are supported");
   end

   if (ldr_pkg::LDR_TOT_BITS != TB) begin : g_chk_tb
      $error("ldr_top: total address width disagrees with package");
   end

   if (ldr_pkg::LDR_DEPTH != (1 << TB)) begin : g_chk_depth
      $error("ldr_top: array depth disagrees with package");
   end

   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        s3;
      logic        lvl;
      logic [1:0]  mode;
      logic        fall;
      logic        we0;
      logic        we1;
      logic [TB-1:0] wa0;
      logic [TB-1:0] wa1;
      logic        wd0;
      logic        wd1;
      logic        last_we;
      logic [7:0]  wcnt;
      logic        ack;
      logic [31:0] rdat;
   } ldr_top_st_t;

   ldr_top_st_t st_q;
   ldr_top_st_t st_d;
   logic        rd0;
   logic        rd1;
   logic [TB-1:0] ra0;
   logic [TB-1:0] ra1;
   logic        act_edge;
   logic        bus_req;
   logic          ctrl_hit;
   logic          stat_hit;
   logic          ctrl_wr;
   logic [TB-1:0] nxt_wa0;
   logic [TB-1:0] nxt_wa1;
   logic          nxt_wd1;
   logic          nxt_we1;

   // lower array sits at addresses 0..15, upper at 16..31
   function automatic logic [TB-1:0] ldr_lo(input logic [LOC_BITS-1:0] a);
      ldr_lo = {1'b0, a};
   endfunction : ldr_lo

   function automatic logic [TB-1:0] ldr_hi(input logic [LOC_BITS-1:0] a);
      ldr_hi = {1'b1, a};
   endfunction : ldr_hi

   // organisation decode, shared by read and write steering
   function automatic logic ldr_is_sp32(input logic [1:0] m);
      ldr_is_sp32 = (m == ldr_pkg::LDR_MODE_SP32);
   endfunction : ldr_is_sp32

   function automatic logic ldr_is_pair(input logic [1:0] m);
      ldr_is_pair = (m == ldr_pkg::LDR_MODE_SP16X2);
   endfunction : ldr_is_pair

   function automatic logic ldr_is_dual(input logic [1:0] m);
      ldr_is_dual = (m == ldr_pkg::LDR_MODE_DP16);
   endfunction : ldr_is_dual

   // port A address: the upper bit only counts in the 32x1 organisation
   function automatic logic [TB-1:0] ldr_port_a(input logic [1:0]          m,
                                                input logic                u,
                                                input logic [LOC_BITS-1:0] a);
      ldr_port_a = ldr_is_sp32(m) ? {u, a} : ldr_lo(a);
   endfunction : ldr_port_a

   // a level change counts once stages two and three agree on it
   function automatic logic ldr_edge_seen(input logic s2,
                                          input logic s3,
                                          input logic lvl,
                                          input logic fall);
      ldr_edge_seen = (s2 == s3) && (s3 != lvl) && (s3 == ~fall);
   endfunction : ldr_edge_seen

   // control word as software reads it back
   function automatic logic [31:0] ldr_ctrl_word(input logic [1:0] m,
                                                 input logic       f);
      ldr_ctrl_word = ldr_pkg::LDR_UNMAPPED;
      ldr_ctrl_word[ldr_pkg::LDR_CTRL_MODE_LSB +: 2] = m;
      ldr_ctrl_word[ldr_pkg::LDR_CTRL_FALL_BIT]      = f;
   endfunction : ldr_ctrl_word

   // status word: counter, last enable, filtered level, both reads
   function automatic logic [31:0] ldr_stat_word(input logic [7:0] c,
                                                 input logic       w,
                                                 input logic       l,
                                                 input logic       r0,
                                                 input logic       r1);
      ldr_stat_word = ldr_pkg::LDR_UNMAPPED;
      ldr_stat_word[ldr_pkg::LDR_STAT_CNT_LSB +: 8] = c;
      ldr_stat_word[ldr_pkg::LDR_STAT_LAST_WE]      = w;
      ldr_stat_word[ldr_pkg::LDR_STAT_WCLK_LVL]     = l;
      ldr_stat_word[ldr_pkg::LDR_STAT_RD0]          = r0;
      ldr_stat_word[ldr_pkg::LDR_STAT_RD1]          = r1;
   endfunction : ldr_stat_word

   // read address steering per organisation
   always_comb begin
      ra0 = ldr_port_a(st_q.mode, i_upper_addr_bit, i_addr);
      ra1 = ldr_hi(i_independent_read_addr);
   end

   // write steering per organisation, used only on an enabled capture
   always_comb begin
      nxt_wa0 = ldr_port_a(st_q.mode, i_upper_addr_bit, i_addr);
      nxt_wa1 = ldr_hi(i_addr);
      nxt_wd1 = i_write_data_in;
      nxt_we1 = 1'b0;
      if (ldr_is_pair(st_q.mode)) begin
         // second array: own address and data, shared enable
         nxt_we1 = 1'b1;
         nxt_wa1 = ldr_hi(i_independent_read_addr);
         nxt_wd1 = i_second_write_data_in;
      end else if (ldr_is_dual(st_q.mode)) begin
         // both copies written at the first address
         nxt_we1 = 1'b1;
      end
   end

   // register decode; only the low byte lane reaches control
   always_comb begin
      ctrl_hit = (i_wb_adr == ldr_pkg::LDR_OFS_CTRL);
      stat_hit = (i_wb_adr == ldr_pkg::LDR_OFS_STATUS);
      ctrl_wr  = bus_req && ctrl_hit && i_wb_we && i_wb_sel[0];
   end

   // filtered write clock level changes; active edge picked by polarity bit
   assign act_edge = ldr_edge_seen(st_q.s2, st_q.s3, st_q.lvl, st_q.fall);
   assign bus_req  = i_wb_cyc && i_wb_stb && !st_q.ack;

   always_comb begin
      st_d     = st_q;
      st_d.s1  = i_write_clk;
      st_d.s2  = st_q.s1;
      st_d.s3  = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
         st_d.lvl = st_q.s3;
      end
      // internal write pulses last one cycle after the capture edge
      st_d.we0 = 1'b0;
      st_d.we1 = 1'b0;
      if (act_edge) begin
         // enable sampled as is, high means write
         st_d.last_we = i_write_en;
         st_d.wd0 = i_write_data_in;
         st_d.wd1 = nxt_wd1;
         st_d.wa0 = nxt_wa0;
         st_d.wa1 = nxt_wa1;
         if (i_write_en) begin
            // counter wraps; software sees it modulo 256
            st_d.wcnt = st_q.wcnt + 8'h01;
            st_d.we0  = 1'b1;
            st_d.we1  = nxt_we1;
         end
      end
      // wishbone: one ack per request, dropped the next cycle
      st_d.ack = bus_req;
      if (bus_req) begin
         st_d.rdat = ldr_pkg::LDR_UNMAPPED;
         if (ctrl_hit) begin
            st_d.rdat = ldr_ctrl_word(st_q.mode, st_q.fall);
         end else if (stat_hit) begin
            st_d.rdat = ldr_stat_word(st_q.wcnt, st_q.last_we, st_q.lvl, rd0, rd1);
         end
      end
      // a polarity change mid-frame may be seen as an edge; change it idle
      if (ctrl_wr) begin
         st_d.mode = i_wb_dat[ldr_pkg::LDR_CTRL_MODE_LSB +: 2];
         st_d.fall = i_wb_dat[ldr_pkg::LDR_CTRL_FALL_BIT];
      end
   end

   // reset clears control and status state; the array has no reset path
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q      <= '0;
         st_q.mode <= ldr_pkg::LDR_MODE_RST;
         st_q.fall <= ldr_pkg::LDR_FALL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   ldr_mem #(
      .ABITS (TB),
      .INIT  (INIT)
   ) u_mem (
      .i_clk    (i_clk),
      .i_we0    (st_q.we0),
      .i_waddr0 (st_q.wa0),
      .i_wdata0 (st_q.wd0),
      .i_we1    (st_q.we1),
      .i_waddr1 (st_q.wa1),
      .i_wdata1 (st_q.wd1),
      .i_raddr0 (ra0),
      .i_raddr1 (ra1),
      .o_rdata0 (rd0),
      .o_rdata1 (rd1)
   );

   // write-through: a new value reaches the output two cycles after the pulse
   assign o_addressed_read_out = rd0;
   assign o_second_read_out    = rd1;
   assign o_wb_dat             = st_q.rdat;
   assign o_wb_ack             = st_q.ack;

endmodule : ldr_top
`default_nettype wire

// [verif/ldr_top_chk.sv]
// port assertions for ldr_top
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module ldr_top_chk #(parameter int LOC_BITS = 4) (
   // bus side
   input wire logic                i_clk,
   input wire logic                i_rst_n,
   input wire logic                i_wb_cyc,
   input wire logic                i_wb_stb,
   input wire logic [7:0]          i_wb_adr,
   input wire logic [31:0]         o_wb_dat,
   input wire logic                o_wb_ack,
   // memory side
   input wire logic                i_write_clk,
   input wire logic                i_write_en,
   input wire logic [LOC_BITS-1:0] i_addr,
   input wire logic                i_upper_addr_bit,
   input wire logic [LOC_BITS-1:0] i_independent_read_addr,
   input wire logic                o_addressed_read_out,
   input wire logic                o_second_read_out
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // eight cycles outlast the synchroniser, write pulse and read register
   sequence s_quiet_a;
      ($stable(i_write_clk) && $stable({i_addr, i_upper_addr_bit}) && !i_wb_stb) [*8];
   endsequence
   sequence s_we_low;
      (!i_write_en && $stable({i_addr, i_upper_addr_bit}) && !i_wb_stb) [*8];
   endsequence
   sequence s_quiet_b;
      ($stable(i_write_clk) && $stable(i_independent_read_addr) && !i_wb_stb) [*8];
   endsequence
   a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack late");
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack too long");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_stb))
      else $error("ack without strobe");
   a_ack_idle: assert property (!i_wb_cyc |=> !o_wb_ack)
      else $error("ack outside cycle");
   a_unmapped_zero: assert property (o_wb_ack && $past(i_wb_adr) > 8'h07 |-> o_wb_dat == 32'h0)
      else $error("unmapped data not zero");
   a_hold_no_wclk: assert property (s_quiet_a |-> $stable(o_addressed_read_out))
      else $error("read changed without write clock");
   a_hold_we_low: assert property (s_we_low |-> $stable(o_addressed_read_out))
      else $error("read changed with enable low");
   a_hold_second: assert property (s_quiet_b |-> $stable(o_second_read_out))
      else $error("second read changed");
endmodule : ldr_top_chk
bind ldr_top ldr_top_chk #(.LOC_BITS(LOC_BITS)) u_chk (.i_clk, .i_rst_n, .i_wb_cyc,
   .i_wb_stb, .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_write_clk, .i_write_en, .i_addr,
   .i_upper_addr_bit, .i_independent_read_addr, .o_addressed_read_out, .o_second_read_out);
`default_nettype wire

// [verif/ldr_user.sv]
// user logic model driving the memory write side
// assumes the bench holds the addresses while o_busy is high
`timescale 1ns/1ps
`default_nettype none
module ldr_user (
   // from bench
   input wire logic       i_clk,
   input wire logic       i_go,
   input wire logic       i_fall,
   input wire logic       i_we,
   input wire logic [1:0] i_d,
   // to memory
   output logic           o_wclk,
   output logic           o_we,
   output logic     [1:0] o_d,
   output logic           o_busy
);
   int         cnt_q = 0;
   logic       we_q = 1'b0;
   logic [1:0] d_q = 2'h0;
   always @(posedge i_clk) begin
      if (i_go && cnt_q == 0) begin
         cnt_q <= 16;
         we_q <= i_we;
         d_q <= i_d;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
      end
      // released lines carry garbage, not the last value
      if (cnt_q == 1) begin
         we_q <= 1'b0;
         d_q <= ~d_q;
      end
   end
   // active level for eight cycles, inputs held long past the edge
   assign o_wclk = (cnt_q > 4 && cnt_q < 13) ? ~i_fall : i_fall;
   assign o_we = we_q;
   assign o_d = d_q;
   assign o_busy = cnt_q != 0;
endmodule : ldr_user
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for ldr_top with a user-logic write model
// assumes ldr_pkg, ldr_top, ldr_user and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {logic [1:0] m; logic [3:0] a; logic u; logic [3:0] ia;
      logic w; logic [1:0] d; logic ea; logic eb;} ldr_row_t;
   logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        go = 1'b0, fall = 1'b0, pwe = 1'b0, ub = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [3:0]  a = 4'h0, ia = 4'h0;
   logic [1:0]  pd = 2'h0, wd;
   logic        ack, wclk, wen, busy, out_a, out_b;
   int          n_errors = 0, checked = 0;
   ldr_row_t    rows [7] = '{
      '{2'h0, 4'h5, 1'b0, 4'h5, 1'b1, 2'h1, 1'b1, 1'b0},
      '{2'h0, 4'h5, 1'b0, 4'h5, 1'b0, 2'h0, 1'b1, 1'b0},
      '{2'h1, 4'h3, 1'b0, 4'h9, 1'b1, 2'h3, 1'b1, 1'b1},
      '{2'h2, 4'h9, 1'b1, 4'h9, 1'b1, 2'h0, 1'b0, 1'b0},
      '{2'h2, 4'h5, 1'b0, 4'h9, 1'b0, 2'h0, 1'b1, 1'b0},
      '{2'h3, 4'h7, 1'b0, 4'h7, 1'b1, 2'h1, 1'b1, 1'b1},
      '{2'h3, 4'h2, 1'b0, 4'h3, 1'b1, 2'h1, 1'b1, 1'b0}};
   always #2.5 clk = ~clk;
   ldr_user i_ldr_user (.i_clk(clk), .i_go(go), .i_fall(fall), .i_we(pwe), .i_d(pd),
      .o_wclk(wclk), .o_we(wen), .o_d(wd), .o_busy(busy));
   ldr_top i_ldr_top (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_write_clk(wclk), .i_write_en(wen), .i_addr(a),
      .i_upper_addr_bit(ub), .i_independent_read_addr(ia), .i_write_data_in(wd[0]),
      .i_second_write_data_in(wd[1]), .o_addressed_read_out(out_a),
      .o_second_read_out(out_b));
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   task automatic guard(input int n);
      if (n >= 40) begin
         n_errors++;
         conclude();
      end
   endtask : guard
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
      int n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      guard(n);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   // one write-clock pulse from the model, then time for the read path
   task automatic mw(input logic w, input logic [1:0] d);
      int n = 0;
      go <= 1'b1;
      pwe <= w;
      pd <= d;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      guard(n);
      repeat (4) @(posedge clk);
   endtask : mw
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("initial", 32'h0, {31'h0, out_a});
      foreach (rows[i]) begin
         wb(1'b1, 8'h00, {30'h0, rows[i].m}, q);
         a <= rows[i].a;
         ub <= rows[i].u;
         ia <= rows[i].ia;
         mw(rows[i].w, rows[i].d);
         chk("addressed", {31'h0, rows[i].ea}, {31'h0, out_a});
         chk("second", {31'h0, rows[i].eb}, {31'h0, out_b});
      end
      wb(1'b0, 8'h04, 32'h0, q);
      chk("status word", 32'h0000_0505, q);
      wb(1'b0, 8'h40, 32'h0, q);
      chk("unmapped", 32'h0, q);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wb(1'b0, 8'h00, 32'h0, q);
      chk("ctrl reset", 32'h0, {29'h0, q[2:0]});
      chk("kept", 32'h1, {31'h0, out_a});
      wb(1'b1, 8'h00, 32'h4, q);
      fall <= 1'b1;
      a <= 4'h4;
      mw(1'b1, 2'h1);
      chk("falling write", 32'h1, {31'h0, out_a});
      conclude();
   end
endmodule : tb_top
`default_nettype wire
